// ---- src/dufr_pkg.sv ----
package dufr_pkg;

    // -----------------------------------------------------------------
    // bus geometry
    // -----------------------------------------------------------------
    localparam int          CH_NUM          = 2;
    localparam int          ADDR_W          = 3;
    localparam int          DATA_W          = 8;
    localparam int          CNT_W           = 7;

    // -----------------------------------------------------------------
    // register offsets
    // -----------------------------------------------------------------
    localparam logic [2:0]  OFS_DATA        = 3'h0;
    localparam logic [2:0]  OFS_DIV_LO      = 3'h0;
    localparam logic [2:0]  OFS_DIV_HI      = 3'h1;
    localparam logic [2:0]  OFS_INT_EN      = 3'h1;
    localparam logic [2:0]  OFS_FIFO_CTRL   = 3'h2;
    localparam logic [2:0]  OFS_ENH_FEAT    = 3'h2;
    localparam logic [2:0]  OFS_LINE_CTRL   = 3'h3;
    localparam logic [2:0]  OFS_MODEM_CTRL  = 3'h4;
    localparam logic [2:0]  OFS_RESUME_1    = 3'h4;
    localparam logic [2:0]  OFS_LINE_STAT   = 3'h5;
    localparam logic [2:0]  OFS_RESUME_2    = 3'h5;
    localparam logic [2:0]  OFS_MODEM_STAT  = 3'h6;
    localparam logic [2:0]  OFS_STOP_1      = 3'h6;
    localparam logic [2:0]  OFS_FLOW_THR    = 3'h6;
    localparam logic [2:0]  OFS_STOP_2      = 3'h7;
    localparam logic [2:0]  OFS_TRIG_LVL    = 3'h7;
    localparam logic [2:0]  OFS_READINESS   = 3'h7;
    localparam logic [2:0]  OFS_SCRATCH     = 3'h7;

    // -----------------------------------------------------------------
    // field positions and key values
    // -----------------------------------------------------------------
    localparam logic [7:0]  LCR_BANK_KEY    = 8'hBF;
    localparam int          LCR_DIV_BIT     = 7;
    localparam int          EFR_ENH_BIT     = 4;
    localparam int          IER_SLEEP_BIT   = 4;
    localparam int          MCR_RDY_EN_BIT  = 2;
    localparam int          MCR_LOOP_BIT    = 4;
    localparam int          MCR_BANK_BIT    = 6;
    localparam int          MCR_PRESC_BIT   = 7;
    localparam logic [7:0]  IER_PROT_MASK   = 8'hF0;
    localparam logic [7:0]  FCR_PROT_MASK   = 8'h30;
    localparam logic [7:0]  MCR_PROT_MASK   = 8'hE0;
    localparam int          RDY_TX_A        = 0;
    localparam int          RDY_TX_B        = 1;
    localparam int          RDY_RX_A        = 4;
    localparam int          RDY_RX_B        = 5;
    localparam logic [7:0]  IIR_IDLE        = 8'h01;

    // -----------------------------------------------------------------
    // trigger levels
    // -----------------------------------------------------------------
    localparam logic [6:0]  TRIG_STEP       = 7'h04;
    localparam logic [27:0] FCR_TX_LVL      = {7'h38, 7'h20, 7'h10, 7'h08};
    localparam logic [27:0] FCR_RX_LVL      = {7'h3C, 7'h38, 7'h10, 7'h08};

    // -----------------------------------------------------------------
    // carriers
    // -----------------------------------------------------------------
    typedef struct packed {
        logic [6:0] tx_space;
        logic [6:0] rx_count;
        logic       rx_timeout;
        logic [7:0] line_status;
        logic [7:0] modem_status;
        logic [7:0] rx_char;
    } dufr_fifo_stat_t;

    typedef struct packed {
        logic [7:0] div_lo;
        logic [7:0] div_hi;
        logic [7:0] int_en;
        logic [7:0] fifo_ctrl;
        logic [7:0] line_ctrl;
        logic [7:0] modem_ctrl;
        logic [7:0] enh_feat;
        logic [7:0] resume_1;
        logic [7:0] resume_2;
        logic [7:0] stop_1;
        logic [7:0] stop_2;
        logic [7:0] flow_thr;
        logic [7:0] trig_lvl;
    } dufr_chan_cfg_t;

    localparam dufr_chan_cfg_t CFG_RST      = '0;
    localparam logic [7:0]     SCRATCH_RST  = 8'h00;

    typedef enum logic [1:0] {
        BANK_NORMAL,
        BANK_DIVISOR,
        BANK_ENHANCED
    } dufr_bank_t;

endpackage : dufr_pkg

// ---- src/dufr_trig_eval.sv ----
`timescale 1ns/10ps
module dufr_trig_eval
    import dufr_pkg::*;
#(
    parameter int CW = CNT_W
) (
    // clock and reset
    input  wire logic            mclk,
    input  wire logic            srst,
    // configuration
    input  wire logic [7:0]      fifo_ctrl,
    input  wire logic [7:0]      trig_lvl,
    // fifo state
    input  wire logic [CW-1:0]   tx_space,
    input  wire logic [CW-1:0]   rx_count,
    input  wire logic            rx_timeout,
    // readiness
    output logic                 tx_rdy_ff,
    output logic                 rx_rdy_ff
);

    if (CW < 7) begin : g_bad_width
        $error("dufr_trig_eval: count width too small for 64-entry fifos");
    end

    // -----------------------------------------------------------------
    // level selection
    // -----------------------------------------------------------------
    logic [6:0] tx_level;
    logic [6:0] rx_level;

    always_comb begin
        if (trig_lvl[3:0] != 4'h0) begin
            tx_level = 7'({3'h0, trig_lvl[3:0]} * TRIG_STEP);
        end else begin
            tx_level = FCR_TX_LVL[fifo_ctrl[5:4]*7 +: 7];
        end
        if (trig_lvl[7:4] != 4'h0) begin
            rx_level = 7'({3'h0, trig_lvl[7:4]} * TRIG_STEP);
        end else begin
            rx_level = FCR_RX_LVL[fifo_ctrl[7:6]*7 +: 7];
        end
    end

    // -----------------------------------------------------------------
    // readiness flags
    // -----------------------------------------------------------------
    // tx space test
    always_ff @(posedge mclk) begin
        if (srst) begin
            tx_rdy_ff <= 1'b0;
        end else begin
            tx_rdy_ff <= (tx_space >= CW'(tx_level));
        end
    end

    always_ff @(posedge mclk) begin
        if (srst) begin
            rx_rdy_ff <= 1'b0;
        end else begin
            rx_rdy_ff <= (rx_count > CW'(rx_level)) || rx_timeout;
        end
    end

endmodule : dufr_trig_eval

// ---- src/dufr_regs.sv ----
`timescale 1ns/10ps
module dufr_regs
    import dufr_pkg::*;
(
    // clock and reset
    input  wire logic              mclk,
    input  wire logic              srst,
    // host bus
    input  wire logic [2:0]        addr,
    input  wire logic [7:0]        data_in,
    output logic [7:0]             data_out_ff,
    output logic                   data_oe_n_ff,
    input  wire logic              cs_a_n,
    input  wire logic              cs_b_n,
    input  wire logic              ior_n,
    input  wire logic              iow_n,
    // channel fifo state
    input  dufr_fifo_stat_t        stat_a,
    input  dufr_fifo_stat_t        stat_b,
    // channel configuration
    output dufr_chan_cfg_t         cfg_a,
    output dufr_chan_cfg_t         cfg_b,
    output logic                   presc_div4_a,
    output logic                   presc_div4_b,
    // data port strobes
    output logic [CH_NUM-1:0]      tx_wr_ff,
    output logic [7:0]             tx_data_ff,
    output logic [CH_NUM-1:0]      rx_rd_ff
);

    // -----------------------------------------------------------------
    // access qualification
    // -----------------------------------------------------------------
    dufr_chan_cfg_t    cfg_ff [CH_NUM];
    logic [7:0]        scratch_ff [CH_NUM];
    logic              iow_n_q_ff;
    logic              ior_n_q_ff;
    logic              acc_sel;
    logic              sel_ch;
    logic              wr_go;
    logic              rd_go;
    logic              rd_edge;
    dufr_chan_cfg_t    cur;
    dufr_bank_t        cur_bank;
    logic              enh_en;
    logic              thr_win;
    logic              rdy_win;
    dufr_fifo_stat_t   stat [CH_NUM];
    logic [CH_NUM-1:0] tx_rdy;
    logic [CH_NUM-1:0] rx_rdy;
    logic [7:0]        rdy_val;
    logic [7:0]        rd_val;

    assign stat[0] = stat_a;
    assign stat[1] = stat_b;

    // channel A has priority if both selects are low together
    assign acc_sel = !cs_a_n || !cs_b_n;
    assign sel_ch  = cs_a_n;
    assign cur     = cfg_ff[sel_ch];

    // one write per falling edge of the write strobe
    assign wr_go   = acc_sel && !iow_n && iow_n_q_ff;
    assign rd_go   = acc_sel && !ior_n;
    assign rd_edge = rd_go && ior_n_q_ff;

    always_ff @(posedge mclk) begin
        if (srst) begin
            iow_n_q_ff <= 1'b1;
            ior_n_q_ff <= 1'b1;
        end else begin
            iow_n_q_ff <= iow_n;
            ior_n_q_ff <= ior_n;
        end
    end

    // -----------------------------------------------------------------
    // bank decode
    // -----------------------------------------------------------------
    always_comb begin
        if (cur.line_ctrl == LCR_BANK_KEY) begin
            cur_bank = BANK_ENHANCED;
        end else if (cur.line_ctrl[LCR_DIV_BIT]) begin
            cur_bank = BANK_DIVISOR;
        end else begin
            cur_bank = BANK_NORMAL;
        end
    end

    assign enh_en  = cur.enh_feat[EFR_ENH_BIT];
    assign thr_win = (cur_bank == BANK_NORMAL) && enh_en && cur.modem_ctrl[MCR_BANK_BIT];
    assign rdy_win = (cur_bank == BANK_NORMAL) && cur.modem_ctrl[MCR_RDY_EN_BIT]
                     && !cur.modem_ctrl[MCR_LOOP_BIT];

    // protected bits keep their value unless enhanced functions are on
    function automatic logic [7:0] guard_wr(input logic [7:0] old_v, input logic [7:0] new_v,
                                            input logic [7:0] prot, input logic en);
        guard_wr = en ? new_v : ((old_v & prot) | (new_v & ~prot));
    endfunction : guard_wr

    // -----------------------------------------------------------------
    // configuration registers
    // -----------------------------------------------------------------
    always_ff @(posedge mclk) begin
        if (srst) begin
            for (int c = 0; c < CH_NUM; c++) begin
                cfg_ff[c] <= CFG_RST;
            end
        end else if (wr_go) begin
            unique case (cur_bank)
                BANK_ENHANCED: begin
                    unique case (addr)
                        OFS_DIV_LO: begin
                            if (!cur.int_en[IER_SLEEP_BIT]) begin
                                cfg_ff[sel_ch].div_lo <= data_in;
                            end
                        end
                        OFS_DIV_HI: begin
                            if (!cur.int_en[IER_SLEEP_BIT]) begin
                                cfg_ff[sel_ch].div_hi <= data_in;
                            end
                        end
                        OFS_ENH_FEAT:   cfg_ff[sel_ch].enh_feat <= data_in;
                        OFS_LINE_CTRL:  cfg_ff[sel_ch].line_ctrl <= data_in;
                        OFS_RESUME_1:   cfg_ff[sel_ch].resume_1 <= data_in;
                        OFS_RESUME_2:   cfg_ff[sel_ch].resume_2 <= data_in;
                        OFS_STOP_1:     cfg_ff[sel_ch].stop_1 <= data_in;
                        OFS_STOP_2:     cfg_ff[sel_ch].stop_2 <= data_in;
                    endcase
                end
                BANK_DIVISOR: begin
                    unique case (addr)
                        OFS_DIV_LO: begin
                            if (!cur.int_en[IER_SLEEP_BIT]) begin
                                cfg_ff[sel_ch].div_lo <= data_in;
                            end
                        end
                        OFS_DIV_HI: begin
                            if (!cur.int_en[IER_SLEEP_BIT]) begin
                                cfg_ff[sel_ch].div_hi <= data_in;
                            end
                        end
                        OFS_FIFO_CTRL: begin
                            cfg_ff[sel_ch].fifo_ctrl <= guard_wr(cur.fifo_ctrl, data_in, FCR_PROT_MASK, enh_en);
                        end
                        OFS_LINE_CTRL:  cfg_ff[sel_ch].line_ctrl <= data_in;
                        OFS_MODEM_CTRL: begin
                            cfg_ff[sel_ch].modem_ctrl <= guard_wr(cur.modem_ctrl, data_in, MCR_PROT_MASK, enh_en);
                        end
                        default: ;
                    endcase
                end
                BANK_NORMAL: begin
                    unique case (addr)
                        OFS_INT_EN: begin
                            cfg_ff[sel_ch].int_en <= guard_wr(cur.int_en, data_in, IER_PROT_MASK, enh_en);
                        end
                        OFS_FIFO_CTRL: begin
                            cfg_ff[sel_ch].fifo_ctrl <= guard_wr(cur.fifo_ctrl, data_in, FCR_PROT_MASK, enh_en);
                        end
                        OFS_LINE_CTRL:  cfg_ff[sel_ch].line_ctrl <= data_in;
                        OFS_MODEM_CTRL: begin
                            cfg_ff[sel_ch].modem_ctrl <= guard_wr(cur.modem_ctrl, data_in, MCR_PROT_MASK, enh_en);
                        end
                        OFS_FLOW_THR: begin
                            if (thr_win) begin
                                cfg_ff[sel_ch].flow_thr <= data_in;
                            end
                        end
                        OFS_TRIG_LVL: begin
                            if (thr_win) begin
                                cfg_ff[sel_ch].trig_lvl <= data_in;
                            end
                        end
                        default: ;
                    endcase
                end
            endcase
        end
    end

    // -----------------------------------------------------------------
    // scratch register
    // -----------------------------------------------------------------
    // readiness never takes a write
    always_ff @(posedge mclk) begin
        if (srst) begin
            for (int c = 0; c < CH_NUM; c++) begin
                scratch_ff[c] <= SCRATCH_RST;
            end
        end else if (wr_go && cur_bank == BANK_NORMAL && addr == OFS_SCRATCH && !thr_win) begin
            scratch_ff[sel_ch] <= data_in;
        end
    end

    // -----------------------------------------------------------------
    // data port strobes
    // -----------------------------------------------------------------
    always_ff @(posedge mclk) begin
        if (srst) begin
            tx_wr_ff   <= '0;
            tx_data_ff <= 8'h00;
            rx_rd_ff   <= '0;
        end else begin
            tx_wr_ff <= '0;
            rx_rd_ff <= '0;
            if (wr_go && cur_bank == BANK_NORMAL && addr == OFS_DATA) begin
                tx_wr_ff[sel_ch] <= 1'b1;
                tx_data_ff       <= data_in;
            end
            if (rd_edge && cur_bank == BANK_NORMAL && addr == OFS_DATA) begin
                rx_rd_ff[sel_ch] <= 1'b1;
            end
        end
    end

    // -----------------------------------------------------------------
    // readiness evaluation
    // -----------------------------------------------------------------
    for (genvar g = 0; g < CH_NUM; g++) begin : g_trig
        dufr_trig_eval #(
            .CW(CNT_W)
        ) u_trig (
            .mclk       (mclk),
            .srst       (srst),
            .fifo_ctrl  (cfg_ff[g].fifo_ctrl),
            .trig_lvl   (cfg_ff[g].trig_lvl),
            .tx_space   (stat[g].tx_space),
            .rx_count   (stat[g].rx_count),
            .rx_timeout (stat[g].rx_timeout),
            .tx_rdy_ff  (tx_rdy[g]),
            .rx_rdy_ff  (rx_rdy[g])
        );
    end

    always_comb begin
        rdy_val           = 8'h00;
        rdy_val[RDY_TX_A] = tx_rdy[0];
        rdy_val[RDY_TX_B] = tx_rdy[1];
        rdy_val[RDY_RX_A] = rx_rdy[0];
        rdy_val[RDY_RX_B] = rx_rdy[1];
    end

    // -----------------------------------------------------------------
    // read mux
    // -----------------------------------------------------------------
    always_comb begin
        rd_val = 8'h00;
        unique case (cur_bank)
            BANK_ENHANCED: begin
                unique case (addr)
                    OFS_DIV_LO:    rd_val = cur.div_lo;
                    OFS_DIV_HI:    rd_val = cur.div_hi;
                    OFS_ENH_FEAT:  rd_val = cur.enh_feat;
                    OFS_LINE_CTRL: rd_val = cur.line_ctrl;
                    OFS_RESUME_1:  rd_val = cur.resume_1;
                    OFS_RESUME_2:  rd_val = cur.resume_2;
                    OFS_STOP_1:    rd_val = cur.stop_1;
                    OFS_STOP_2:    rd_val = cur.stop_2;
                endcase
            end
            BANK_DIVISOR: begin
                unique case (addr)
                    OFS_DIV_LO:     rd_val = cur.div_lo;
                    OFS_DIV_HI:     rd_val = cur.div_hi;
                    OFS_FIFO_CTRL:  rd_val = IIR_IDLE;
                    OFS_LINE_CTRL:  rd_val = cur.line_ctrl;
                    OFS_MODEM_CTRL: rd_val = cur.modem_ctrl;
                    OFS_LINE_STAT:  rd_val = stat[sel_ch].line_status;
                    OFS_MODEM_STAT: rd_val = stat[sel_ch].modem_status;
                    OFS_SCRATCH:    rd_val = scratch_ff[sel_ch];
                endcase
            end
            BANK_NORMAL: begin
                unique case (addr)
                    OFS_DATA:       rd_val = stat[sel_ch].rx_char;
                    OFS_INT_EN:     rd_val = cur.int_en;
                    OFS_FIFO_CTRL:  rd_val = IIR_IDLE;
                    OFS_LINE_CTRL:  rd_val = cur.line_ctrl;
                    OFS_MODEM_CTRL: rd_val = cur.modem_ctrl;
                    OFS_LINE_STAT:  rd_val = stat[sel_ch].line_status;
                    OFS_FLOW_THR:   rd_val = thr_win ? cur.flow_thr : stat[sel_ch].modem_status;
                    OFS_SCRATCH: begin
                        if (rdy_win) begin
                            rd_val = rdy_val;
                        end else if (thr_win) begin
                            rd_val = cur.trig_lvl;
                        end else begin
                            rd_val = scratch_ff[sel_ch];
                        end
                    end
                endcase
            end
        endcase
    end

    // -----------------------------------------------------------------
    // bus drive
    // -----------------------------------------------------------------
    always_ff @(posedge mclk) begin
        if (srst) begin
            data_out_ff  <= 8'h00;
            data_oe_n_ff <= 1'b1;
        end else begin
            data_out_ff  <= rd_go ? rd_val : 8'h00;
            data_oe_n_ff <= !rd_go;
        end
    end

    // -----------------------------------------------------------------
    // configuration outputs
    // -----------------------------------------------------------------
    assign cfg_a = cfg_ff[0];
    assign cfg_b = cfg_ff[1];
    assign presc_div4_a = cfg_ff[0].modem_ctrl[MCR_PRESC_BIT];
    assign presc_div4_b = cfg_ff[1].modem_ctrl[MCR_PRESC_BIT];

endmodule : dufr_regs

// ---- tb/dufr_props.sv ----
`timescale 1ns/10ps
module dufr_props import dufr_pkg::*; (
    // watched ports
    input wire logic           mclk,
    input wire logic           srst,
    input wire logic [2:0]     addr,
    input wire logic           cs_a_n,
    input wire logic           ior_n,
    input wire logic [7:0]     data_out_ff,
    input wire logic           data_oe_n_ff,
    input wire dufr_chan_cfg_t cfg_a,
    input wire logic           presc_div4_a
);
    // ----------------------------------------
    // register access checks
    // ----------------------------------------
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (srst);
    sequence rdy_rd;
        !cs_a_n && !ior_n && addr == 3'h7 && !cfg_a.line_ctrl[7] && cfg_a.modem_ctrl[2] && !cfg_a.modem_ctrl[4];
    endsequence
    rdy_zero_a: assert property (rdy_rd |=> !data_oe_n_ff && (data_out_ff & 8'hCC) == 8'h00) else $error("spare bits set");
    bus_idle_a: assert property (ior_n |=> data_oe_n_ff && data_out_ff == 8'h00) else $error("bus driven unread");
    presc_sel_a: assert property (presc_div4_a == cfg_a.modem_ctrl[7] &&
        (!$changed(presc_div4_a) || $past(cfg_a.enh_feat[4]))) else $error("prescaler wrong");
    div_guard_a: assert property ($changed(cfg_a.div_lo) |-> $past(cfg_a.line_ctrl[7])) else $error("divisor bank");
    char_bank_a: assert property ($changed(cfg_a.stop_1) |-> $past(cfg_a.line_ctrl) == 8'hBF) else $error("char bank");
    enh_bank_a: assert property ($changed(cfg_a.enh_feat) |-> $past(cfg_a.line_ctrl) == 8'hBF) else $error("enh bank");
    thr_guard_a: assert property ($changed(cfg_a.flow_thr) |->
        $past(cfg_a.enh_feat[4]) && $past(cfg_a.modem_ctrl[6])) else $error("threshold guard");
    prot_guard_a: assert property ($changed(cfg_a.modem_ctrl[7:5]) |-> $past(cfg_a.enh_feat[4])) else $error("prot");
endmodule : dufr_props
bind dufr_regs dufr_props u_dufr_props (.mclk, .srst, .addr, .cs_a_n, .ior_n, .data_out_ff, .data_oe_n_ff,
    .cfg_a, .presc_div4_a);

// ---- tb/dufr_host.sv ----
`timescale 1ns/10ps
module dufr_host import dufr_pkg::*; (
    // host bus
    input wire logic       mclk,
    output logic [2:0]     addr,
    output logic [7:0]     data_in,
    output logic           cs_a_n,
    output logic           cs_b_n,
    output logic           ior_n,
    output logic           iow_n,
    input wire logic [7:0] data_out_ff
);
    // ----------------------------------------
    // bus cycles
    // ----------------------------------------
    initial {addr, data_in, cs_a_n, cs_b_n, ior_n, iow_n} = 15'h7FFF;
    task automatic wr(input logic b, input logic [2:0] a, input logic [7:0] d);
        @(negedge mclk);
        {cs_b_n, cs_a_n, addr, data_in, iow_n} = {~b, b, a, d, 1'b0};
        @(negedge mclk);
        {iow_n, cs_a_n, cs_b_n, data_in} = {3'h7, ~d};
    endtask : wr
    task automatic rd(input logic b, input logic [2:0] a, output logic [7:0] q);
        @(negedge mclk);
        {cs_b_n, cs_a_n, addr, ior_n} = {~b, b, a, 1'b0};
        @(negedge mclk);
        q = data_out_ff;
        {ior_n, cs_a_n, cs_b_n} = 3'h7;
    endtask : rd
    task automatic rdy(input logic b, output logic [7:0] q);
        logic [7:0] m;
        rd(b, 3'h4, m);
        wr(b, 3'h4, (m & 8'hEF) | 8'h04);
        rd(b, 3'h7, q);
        wr(b, 3'h4, m);
    endtask : rdy
endmodule : dufr_host

// ---- tb/testbench.sv ----
`timescale 1ns/10ps
module testbench import dufr_pkg::*;;
    // ----------------------------------------
    // bench
    // ----------------------------------------
    localparam logic [7:0] TL = 8'h30;
    localparam logic [7:0] FC = 8'h30;
    logic            mclk, srst, cs_a_n, cs_b_n, ior_n, iow_n, presc_div4_a, presc_div4_b;
    logic [1:0]      tx_wr_ff, rx_rd_ff;
    logic [2:0]      addr;
    logic [7:0]      data_in, data_out_ff, q, tx_data_ff;
    logic [16:0]     r;
    dufr_fifo_stat_t stat_a, stat_b;
    dufr_chan_cfg_t  cfg_a, cfg_b;
    int              miscompares, comparisons;
    dufr_regs u_dufr_regs (.mclk, .srst, .addr, .data_in, .data_out_ff, .data_oe_n_ff(), .cs_a_n, .cs_b_n,
        .ior_n, .iow_n, .stat_a, .stat_b, .cfg_a, .cfg_b, .presc_div4_a, .presc_div4_b, .tx_wr_ff,
        .tx_data_ff, .rx_rd_ff);
    dufr_host u_dufr_host (.mclk, .addr, .data_in, .cs_a_n, .cs_b_n, .ior_n, .iow_n, .data_out_ff);
    initial begin
        mclk = 1'b0;
        forever #2.5 mclk = ~mclk;
    end
    function automatic logic [16:0] lfsr(input logic [16:0] s);
        return {s[15:0], s[16] ^ s[13]};
    endfunction : lfsr
    function automatic logic [6:0] lvl(input logic [3:0] f, input logic [1:0] s, input logic rx);
        return f != 4'h0 ? {1'b0, f, 2'b00} : (rx ? FCR_RX_LVL[s*7 +: 7] : FCR_TX_LVL[s*7 +: 7]);
    endfunction : lvl
    function automatic logic rdy(input dufr_fifo_stat_t s, input logic [7:0] t, input logic [7:0] f, input logic rx);
        return rx ? (s.rx_count > lvl(t[7:4], f[7:6], 1'b1)) | s.rx_timeout : s.tx_space >= lvl(t[3:0], f[5:4], 1'b0);
    endfunction : rdy
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            miscompares++;
            $display("ERROR %0t saw %h expected %h", $time, seen, exp);
        end
    endtask : chk
    task automatic w(input logic [2:0] a, input logic [7:0] d);
        u_dufr_host.wr(1'b0, a, d);
    endtask : w
    task automatic close_out();
        $display("comparisons %0d miscompares %0d", comparisons, miscompares);
        if (miscompares == 0 && comparisons > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : close_out
    initial begin
        #50000;
        miscompares++;
        close_out();
    end
    initial begin
        {srst, stat_a, stat_b, r, miscompares, comparisons} = {1'b1, 78'h0, 17'd78960, 64'h0};
        repeat (3) @(negedge mclk);
        srst = 1'b0;
        u_dufr_host.rd(1'b0, 3'h3, q);
        w(3'h3, 8'h80);
        w(3'h0, 8'h12);
        w(3'h1, 8'h34);
        w(3'h3, q);
        w(3'h0, 8'h55);
        chk({tx_wr_ff, tx_data_ff}, {2'b01, 8'h55});
        chk({cfg_a.div_hi, cfg_a.div_lo}, 32'h3412);
        w(3'h3, 8'hBF);
        for (int a = 4; a < 8; a++) w(a[2:0], 8'hA0 | 8'(a));
        w(3'h2, 8'h10);
        w(3'h3, 8'h00);
        chk({cfg_a.stop_1, cfg_a.resume_1, cfg_a.stop_2, cfg_a.resume_2}, 32'hA6A4A7A5);
        chk(cfg_a.enh_feat, 8'h10);
        w(3'h6, 8'h77);
        chk(cfg_a.flow_thr, 8'h00);
        w(3'h4, 8'hC0);
        chk(presc_div4_a, 1'b1);
        w(3'h6, 8'h77);
        w(3'h7, TL);
        w(3'h2, FC);
        w(3'h4, 8'h40);
        chk(presc_div4_a, 1'b0);
        chk({cfg_a.flow_thr, cfg_a.trig_lvl, cfg_a.fifo_ctrl}, {8'h77, TL, FC});
        for (int i = 0; i < 24; i++) begin
            @(negedge mclk);
            r = lfsr(r);
            stat_a = {r, r, r[4:0]};
            r = lfsr(r);
            stat_b = {r[4:0], r, r};
            if (i < 2) {stat_a.tx_space, stat_a.rx_count, stat_a.rx_timeout} = {7'd56 - 7'(i), 7'd48 + 7'(i), 1'b0};
            u_dufr_host.rdy(i[0], q);
            chk(q, {2'b00, rdy(stat_b, 0, 0, 1), rdy(stat_a, TL, FC, 1), 2'b00, rdy(stat_b, 0, 0, 0),
                rdy(stat_a, TL, FC, 0)});
        end
        stat_a.tx_space = 7'd64;
        w(3'h4, 8'h14);
        u_dufr_host.rd(1'b0, 3'h7, q);
        chk(q, 8'h00);
        u_dufr_host.rd(1'b0, 3'h0, q);
        chk({rx_rd_ff, q}, {2'b01, stat_a.rx_char});
        u_dufr_host.wr(1'b1, 3'h4, 8'hE4);
        chk({presc_div4_b, cfg_b.modem_ctrl}, {1'b0, 8'h04});
        close_out();
    end
endmodule : testbench
